//--- pkg/acs_map.svh
// register offsets, field positions, codes and reset values of the converter sequencer
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_AW            10
`define ACS_DW            8
`define ACS_OFF_PCH       10'h3EC
`define ACS_OFF_ACQ_L     10'h3EE
`define ACS_OFF_ACQ_H     10'h3EF
`define ACS_OFF_PRE_L     10'h3F1
`define ACS_OFF_PRE_H     10'h3F2
`define ACS_OFF_STAT      10'h3F7
`define ACS_OFF_REF       10'h3F8
`define ACS_OFF_CLK       10'h3FA
`define ACS_OFF_CTRL      10'h3D0
`define ACS_OFF_IRQ_STAT  10'h3D1
`define ACS_OFF_IRQ_MASK  10'h3D2
`define ACS_BIT_COMPUTATION_UPDATE_FLAG      4
`define ACS_BIT_NEG_REFERENCE_SELECT      4
`define ACS_CTRL_GO       0
`define ACS_CTRL_CS       1
`define ACS_CTRL_DOUBLE_SAMPLE_ENABLE     2
`define ACS_CTRL_CONTINUOUS_OPERATION     3
`define ACS_IRQ_SAMPLE    0
`define ACS_IRQ_COMPUTATION_UPDATE_FLAG      1
`define ACS_IRQ_W         2
`define ACS_TW            13
`define ACS_CW            14
`define ACS_ACQ_LONG      14'h2000
`define ACS_CNT_ONE       14'h0001
`define ACS_DIV_W         6
`define ACS_DIVC_W        7
`define ACS_ST_IDLE       3'h0
`define ACS_ST_PRE        2'h1
`define ACS_ST_ACQ        2'h2
`define ACS_ST_CNV        2'h3
`define ACS_ST_SUSP       3'h4
`define ACS_POS_REFERENCE_SELECT_FVR      2'h3
`define ACS_POS_REFERENCE_SELECT_EXT      2'h2
`define ACS_POS_REFERENCE_SELECT_VDD      2'h0
`define ACS_PCH_A_LO      6'h00
`define ACS_PCH_A_HI      6'h05
`define ACS_PCH_B_LO      6'h0C
`define ACS_PCH_B_HI      6'h0F
`define ACS_PCH_C_LO      6'h10
`define ACS_PCH_C_HI      6'h17
`define ACS_PCH_INT_LO    6'h3A
`define ACS_RST_BYTE      8'h00
`endif

//--- pkg/acs_pkg.sv
// types shared by the converter sequencer
package acs_pkg;
    typedef enum logic [2:0] {ACS_IDLE, ACS_PRE, ACS_ACQ, ACS_CNV, ACS_SUSP} acs_state_t;
    // analog reference routing
    typedef struct packed {
        logic       neg_ext;   // 1: external negative reference pin, 0: analog ground
        logic       pos_fvr;   // internal fixed reference
        logic       pos_ext;   // external positive reference pin
        logic       pos_vdd;   // supply
    } acs_ref_t;
    // one-hot input channel routing; internal[0] = DAC 2 ... internal[5] = buffer 2
    typedef struct packed {
        logic [5:0] port_a;
        logic [3:0] port_b;    // pins 4 to 7
        logic [7:0] port_c;
        logic [5:0] internal;
    } acs_chan_t;
    // sequencer controls toward the analog core
    typedef struct packed {
        logic       precharge;
        logic       acquire;
        logic       convert;
        logic [2:0] stat;
    } acs_seq_t;
endpackage : acs_pkg

//--- logic/acs_top.sv
// converter sequencer: registers, stage timing, clock divider, analog selects
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "acs_map.svh"
// =====================================================================
// Functional notes
// - computation-update flag (status bit 4) sets when computation results update.
// - flag reads zero only if nothing updated since software last cleared it.
// - software clear of the flag is ignored while stage status is 100.
// - stage codes: 000 idle, 001/010/011 first sample, 101/110/111 second.
// - stage status 100 while suspended between first and second sample.
// - suspension appears between triggers with double-sample on, continuous off.
// - stage status may be invalid with RC clock faster than system clock.
// - divider value n gives converter clock of system clock over 2*(n+1).
// - divider acts only with system clock source; RC source bypasses it.
// - negative reference bit 4: 1 external pin, 0 analog ground.
// - positive reference 11 fixed ref, 10 external pin, 00 supply, 01 reserved.
// - channel codes map to port A 0-5, port B 4-7, port C 0-7.
// - codes 111010 to 111111 select DAC2, ground, temp, DAC1, buffer 1, 2.
// - nonzero precharge n lasts n selected clocks; zero skips precharge.
// - nonzero acquisition n lasts n clocks; zero with zero precharge skips it.
// - acquisition zero with nonzero precharge lasts 8192 clocks.
// - timing registers are byte addressed: high byte 12:8, low byte 7:0.
module acs_top (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic [`ACS_AW-1:0]  reg_addr,
    input  wire logic [`ACS_DW-1:0]  reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [`ACS_DW-1:0]  reg_rdata,
    input  wire logic                trigger,
    input  wire logic                conv_done,
    input  wire logic                result_update,
    input  wire logic                rc_clk_pin,
    output logic                     adc_clk_tick,
    output acs_pkg::acs_seq_t        seq,
    output acs_pkg::acs_ref_t        ref_sel,
    output acs_pkg::acs_chan_t       chan_sel,
    output logic                     irq
);
    import acs_pkg::*;

    // =================================================================
    // channel decode
    function automatic acs_chan_t chan_decode(input logic [5:0] code);
        acs_chan_t c;
        c = '0;
        if (code <= `ACS_PCH_A_HI)
            c.port_a[code[2:0]] = 1'b1;
        else if (code >= `ACS_PCH_B_LO && code <= `ACS_PCH_B_HI)
            c.port_b[code[1:0]] = 1'b1;
        else if (code >= `ACS_PCH_C_LO && code <= `ACS_PCH_C_HI)
            c.port_c[code[2:0]] = 1'b1;
        else if (code >= `ACS_PCH_INT_LO)
            c.internal[3'(code - `ACS_PCH_INT_LO)] = 1'b1;
        return c;
    endfunction : chan_decode

    // =================================================================
    // register storage
    logic [`ACS_DW-1:0] pch_q, ref_q, clk_q, ctrl_q, rdata_q;
    logic [`ACS_TW-1:0] acq_q, pre_q;
    logic [`ACS_IRQ_W-1:0] irq_stat_q, irq_mask_q;
    logic               computation_update_flag_q;
    acs_state_t         st_q, st_d;
    logic               second_q;
    logic [`ACS_CW-1:0] cnt_q;
    logic [`ACS_DIVC_W-1:0] div_q;
    logic               rc_s1_q, rc_s2_q, rc_s3_q;

    // decoded strobes
    wire wr_pch   = reg_wr && reg_addr == `ACS_OFF_PCH;
    wire wr_acq_l = reg_wr && reg_addr == `ACS_OFF_ACQ_L;
    wire wr_acq_h = reg_wr && reg_addr == `ACS_OFF_ACQ_H;
    wire wr_pre_l = reg_wr && reg_addr == `ACS_OFF_PRE_L;
    wire wr_pre_h = reg_wr && reg_addr == `ACS_OFF_PRE_H;
    wire wr_stat  = reg_wr && reg_addr == `ACS_OFF_STAT;
    wire wr_ref   = reg_wr && reg_addr == `ACS_OFF_REF;
    wire wr_clk   = reg_wr && reg_addr == `ACS_OFF_CLK;
    wire wr_ctrl  = reg_wr && reg_addr == `ACS_OFF_CTRL;
    wire wr_mask  = reg_wr && reg_addr == `ACS_OFF_IRQ_MASK;
    wire rd_irq   = reg_rd && reg_addr == `ACS_OFF_IRQ_STAT;

    wire cs_rc    = ctrl_q[`ACS_CTRL_CS];
    wire double_sample_enable     = ctrl_q[`ACS_CTRL_DOUBLE_SAMPLE_ENABLE];
    wire continuous_operation     = ctrl_q[`ACS_CTRL_CONTINUOUS_OPERATION];
    wire go_bit   = ctrl_q[`ACS_CTRL_GO];

    // =================================================================
    // stage status code; second-sample stages carry the top bit
    logic [2:0] stat_w;
    always_comb begin
        case (st_q)
            ACS_PRE:  stat_w = {second_q, `ACS_ST_PRE};
            ACS_ACQ:  stat_w = {second_q, `ACS_ST_ACQ};
            ACS_CNV:  stat_w = {second_q, `ACS_ST_CNV};
            ACS_SUSP: stat_w = `ACS_ST_SUSP;
            default:  stat_w = `ACS_ST_IDLE;
        endcase
    end
    // the status is sampled on mclk; with a fast RC source it may lag the core
    wire suspended = stat_w == `ACS_ST_SUSP;

    // =================================================================
    // RC clock pin: two synchroniser stages, then a rising-edge tick
    always_ff @(posedge mclk) begin
        rc_s1_q <= rst ? 1'b0 : rc_clk_pin;
        rc_s2_q <= rst ? 1'b0 : rc_s1_q;
        rc_s3_q <= rst ? 1'b0 : rc_s2_q;
    end
    wire rc_tick = rc_s2_q && !rc_s3_q;

    // =================================================================
    // divider: one tick every 2*(n+1) system clocks
    wire [`ACS_DIVC_W-1:0] div_last =
        {clk_q[`ACS_DIV_W-1:0], 1'b1};
    wire div_wrap = div_q >= div_last;
    always_ff @(posedge mclk) begin
        if (rst || wr_clk || div_wrap)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end
    // with the RC source the divider is bypassed entirely
    wire adc_tick_d = cs_rc ? rc_tick : div_wrap;

    // =================================================================
    // stage timing: counts system clocks or RC ticks
    wire stage_tick = cs_rc ? rc_tick : 1'b1;
    wire pre_zero   = pre_q == '0;
    wire acq_zero   = acq_q == '0;
    wire skip_acq   = acq_zero && pre_zero;
    wire [`ACS_CW-1:0] acq_load = acq_zero ? `ACS_ACQ_LONG :
                                             {1'b0, acq_q};
    wire cnt_end    = stage_tick && cnt_q == `ACS_CNT_ONE;
    wire start_req  = trigger || (wr_ctrl && reg_wdata[`ACS_CTRL_GO]);
    wire sample_end = st_q == ACS_CNV && conv_done;
    wire last       = !double_sample_enable || second_q;

    // entry into a sample: first non-empty stage
    acs_state_t entry_w;
    assign entry_w = !pre_zero ? ACS_PRE : (!skip_acq ? ACS_ACQ : ACS_CNV);

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            ACS_IDLE: if (start_req) st_d = entry_w;
            ACS_PRE:  if (cnt_end) st_d = ACS_ACQ;
            ACS_ACQ:  if (cnt_end) st_d = ACS_CNV;
            ACS_CNV: begin
                if (conv_done) begin
                    if (!last)
                        st_d = continuous_operation ? entry_w : ACS_SUSP;
                    else
                        st_d = (continuous_operation && go_bit) ? entry_w : ACS_IDLE;
                end
            end
            ACS_SUSP: if (start_req) st_d = entry_w;
            default:  st_d = ACS_IDLE;
        endcase
    end

    // state, sample index and stage counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q     <= ACS_IDLE;
            second_q <= 1'b0;
            cnt_q    <= '0;
        end else begin
            st_q <= st_d;
            if (sample_end)
                second_q <= !last;
            if (st_d == ACS_PRE && st_q != ACS_PRE)
                cnt_q <= {1'b0, pre_q};
            else if (st_d == ACS_ACQ && st_q != ACS_ACQ)
                cnt_q <= acq_load;
            else if (stage_tick && cnt_q != '0)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // =================================================================
    // register writes; timing registers take one byte lane at a time
    always_ff @(posedge mclk) begin
        if (rst) begin
            pch_q  <= `ACS_RST_BYTE;
            ref_q  <= `ACS_RST_BYTE;
            clk_q  <= `ACS_RST_BYTE;
            ctrl_q <= `ACS_RST_BYTE;
            acq_q  <= '0;
            pre_q  <= '0;
        end else begin
            if (wr_pch)   pch_q <= reg_wdata;
            if (wr_ref)   ref_q <= reg_wdata;
            if (wr_clk)   clk_q <= reg_wdata;
            if (wr_acq_l) acq_q[7:0]  <= reg_wdata;
            if (wr_acq_h) acq_q[12:8] <= reg_wdata[4:0];
            if (wr_pre_l) pre_q[7:0]  <= reg_wdata;
            if (wr_pre_h) pre_q[12:8] <= reg_wdata[4:0];
            // go falls by itself when a single-shot run ends
            if (wr_ctrl)
                ctrl_q <= reg_wdata;
            else if (sample_end && last && !continuous_operation)
                ctrl_q[`ACS_CTRL_GO] <= 1'b0;
        end
    end

    // =================================================================
    // computation-update flag: an update beats a clear in the same cycle
    wire computation_update_flag_clr = wr_stat && !reg_wdata[`ACS_BIT_COMPUTATION_UPDATE_FLAG] && !suspended;
    always_ff @(posedge mclk) begin
        if (rst)
            computation_update_flag_q <= 1'b0;
        else if (result_update)
            computation_update_flag_q <= 1'b1;
        else if (computation_update_flag_clr)
            computation_update_flag_q <= 1'b0;
    end

    // =================================================================
    // interrupt status: sticky, cleared by reading, set wins over clear
    wire [`ACS_IRQ_W-1:0] irq_ev = {result_update, sample_end};
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            irq_stat_q <= (rd_irq ? '0 : irq_stat_q) | irq_ev;
            if (wr_mask)
                irq_mask_q <= reg_wdata[`ACS_IRQ_W-1:0];
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // =================================================================
    // read mux; unmapped addresses read zero
    logic [`ACS_DW-1:0] rmux;
    always_comb begin
        case (reg_addr)
            `ACS_OFF_PCH:      rmux = pch_q;
            `ACS_OFF_ACQ_L:    rmux = acq_q[7:0];
            `ACS_OFF_ACQ_H:    rmux = {3'h0, acq_q[12:8]};
            `ACS_OFF_PRE_L:    rmux = pre_q[7:0];
            `ACS_OFF_PRE_H:    rmux = {3'h0, pre_q[12:8]};
            `ACS_OFF_STAT:     rmux = {3'h0, computation_update_flag_q, 1'b0, stat_w};
            `ACS_OFF_REF:      rmux = ref_q;
            `ACS_OFF_CLK:      rmux = clk_q;
            `ACS_OFF_CTRL:     rmux = ctrl_q;
            `ACS_OFF_IRQ_STAT: rmux = {6'h00, irq_stat_q};
            `ACS_OFF_IRQ_MASK: rmux = {6'h00, irq_mask_q};
            default:           rmux = '0;
        endcase
    end

    // =================================================================
    // registered outputs
    acs_ref_t  ref_d;
    assign ref_d.neg_ext = ref_q[`ACS_BIT_NEG_REFERENCE_SELECT];
    assign ref_d.pos_fvr = ref_q[1:0] == `ACS_POS_REFERENCE_SELECT_FVR;
    assign ref_d.pos_ext = ref_q[1:0] == `ACS_POS_REFERENCE_SELECT_EXT;
    assign ref_d.pos_vdd = ref_q[1:0] == `ACS_POS_REFERENCE_SELECT_VDD;
    acs_seq_t  seq_d;
    assign seq_d.precharge = st_d == ACS_PRE;
    assign seq_d.acquire   = st_d == ACS_ACQ;
    assign seq_d.convert   = st_d == ACS_CNV && st_q != ACS_CNV;
    assign seq_d.stat      = stat_w;
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q      <= '0;
            ref_sel      <= '0;
            chan_sel     <= '0;
            seq          <= '0;
            adc_clk_tick <= 1'b0;
        end else begin
            rdata_q      <= reg_rd ? rmux : '0;
            ref_sel      <= ref_d;
            chan_sel     <= chan_decode(pch_q[5:0]);
            seq          <= seq_d;
            adc_clk_tick <= adc_tick_d;
        end
    end
    assign reg_rdata = rdata_q;

    // =================================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_computation_update_flag_set;
        result_update |=> computation_update_flag_q;
    endproperty
    a_computation_update_flag_set: assert property (p_computation_update_flag_set) else $error("update lost");

    property p_computation_update_flag_hold;
        !computation_update_flag_q && !result_update |=> !computation_update_flag_q;
    endproperty
    a_computation_update_flag_hold: assert property (p_computation_update_flag_hold) else $error("flag rose");

    property p_computation_update_flag_susp;
        computation_update_flag_q && suspended && !result_update |=> computation_update_flag_q;
    endproperty
    a_computation_update_flag_susp: assert property (p_computation_update_flag_susp) else $error("cleared");

    property p_susp_code;
        st_q == ACS_SUSP |-> stat_w == `ACS_ST_SUSP && double_sample_enable && !continuous_operation;
    endproperty
    a_susp_code: assert property (p_susp_code) else $error("susp");

    property p_div;
        !cs_rc && div_wrap && !wr_clk ##1 (!wr_clk && !cs_rc) [*1] |->
            !div_wrap;
    endproperty
    a_div: assert property (p_div) else $error("divider");

    property p_rc_bypass;
        cs_rc |=> adc_clk_tick == $past(rc_tick);
    endproperty
    a_rc_bypass: assert property (p_rc_bypass) else $error("bypass");

    property p_order;
        st_q == ACS_PRE && st_d != ACS_PRE |-> st_d == ACS_ACQ;
    endproperty
    a_order: assert property (p_order) else $error("order");

    property p_long_acq;
        st_q == ACS_PRE && st_d == ACS_ACQ && acq_zero |=> cnt_q == `ACS_ACQ_LONG;
    endproperty
    a_long_acq: assert property (p_long_acq) else $error("8192");

    property p_skip_pre;
        st_q == ACS_IDLE && start_req && pre_zero |=> st_q != ACS_PRE;
    endproperty
    a_skip_pre: assert property (p_skip_pre) else $error("skip");

    property p_rdata;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("rdata");

    c_susp:   cover property (st_q == ACS_CNV ##1 st_q == ACS_SUSP);
    c_second: cover property (stat_w == 3'h7);
    c_clear:  cover property (computation_update_flag_q ##1 !computation_update_flag_q);
endmodule : acs_top

//--- bench/tb_acs_top.sv
// self-checking testbench of the converter sequencer registers, stages and selects
`timescale 1ns/1ns
`include "acs_map.svh"
module tb_acs_top;
    import acs_pkg::*;
    logic                mclk;
    logic                rst;
    logic [`ACS_AW-1:0]  reg_addr;
    logic [`ACS_DW-1:0]  reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [`ACS_DW-1:0]  reg_rdata;
    logic                trigger;
    logic                conv_done;
    logic                result_update;
    logic                rc_clk_pin;
    logic                adc_clk_tick;
    acs_seq_t            seq;
    acs_ref_t            ref_sel;
    acs_chan_t           chan_sel;
    logic                irq;
    int                  num_errors;
    int                  num_checks;
    logic [7:0]          rv;
    int                  gap;
    int                  cnt;
    acs_ref_t            er;

    acs_top dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger(trigger),
        .conv_done(conv_done), .result_update(result_update), .rc_clk_pin(rc_clk_pin),
        .adc_clk_tick(adc_clk_tick), .seq(seq), .ref_sel(ref_sel), .chan_sel(chan_sel),
        .irq(irq));

    // =========================================================
    // clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // =========================================================
    // report and compare tasks
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    // =========================================================
    // register bus: one-cycle strobes changed right after the edge
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // 0 trigger, 1 conversion done, 2 result update
    task automatic pulse(input int k);
        @(posedge mclk);
        case (k)
            0: trigger <= 1'b1;
            1: conv_done <= 1'b1;
            default: result_update <= 1'b1;
        endcase
        @(posedge mclk);
        trigger       <= 1'b0;
        conv_done     <= 1'b0;
        result_update <= 1'b0;
    endtask : pulse

    // =========================================================
    // one sample: stage lengths and codes up to conversion, then finish it
    task automatic run_sample(input int ep, input int ea, input logic hi);
        int         pc;
        int         ac;
        int         n;
        logic [2:0] ps;
        logic [2:0] as;
        logic       pp;
        logic       pa;
        pc = 0;
        ac = 0;
        n  = 0;
        ps = 3'h0;
        as = 3'h0;
        pp = 1'b0;
        pa = 1'b0;
        // the stage code on seq lags the stage flags by one cycle
        #1;
        while (seq.convert !== 1'b1) begin
            if (pp) ps = seq.stat;
            if (pa) as = seq.stat;
            pp = seq.precharge === 1'b1;
            pa = seq.acquire === 1'b1;
            if (pp) pc++;
            if (pa) ac++;
            n++;
            if (n > 9000) begin
                num_errors++;
                give_verdict();
            end
            @(posedge mclk);
            #1;
        end
        if (pa) as = seq.stat;
        chk_pin(pc, ep);
        chk_pin(ac, ea);
        if (ep > 0) chk_pin(ps, {hi, 2'h1});
        if (ea > 0) chk_pin(as, {hi, 2'h2});
        @(posedge mclk);
        #1 chk_pin(seq.stat, {hi, 2'h3});
        pulse(1);
    endtask : run_sample

    // cycles from now to the next converter clock tick
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge mclk);
            #1 c++;
        end while (adc_clk_tick !== 1'b1 && c < 200);
        if (c >= 200) begin
            num_errors++;
            give_verdict();
        end
    endtask : wait_tick

    // expected one-hot channel routing for a select code
    function automatic acs_chan_t chan_exp(input int c);
        acs_chan_t e;
        e = '0;
        if (c <= 5) e.port_a[c] = 1'b1;
        else if (c >= 12 && c <= 15) e.port_b[c-12] = 1'b1;
        else if (c >= 16 && c <= 23) e.port_c[c-16] = 1'b1;
        else if (c >= 58) e.internal[c-58] = 1'b1;
        return e;
    endfunction : chan_exp

    // =========================================================
    // hang guard, well above the longest stage
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end

    // =========================================================
    // main sequence
    initial begin
        num_errors = 0;
        num_checks = 0;
        rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
        trigger = 1'b0; conv_done = 1'b0; result_update = 1'b0; rc_clk_pin = 1'b0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(`ACS_OFF_ACQ_L, rv); chk_reg(rv, 8'h00);
        rd(`ACS_OFF_ACQ_H, rv); chk_reg(rv, 8'h00);
        rd(`ACS_OFF_STAT, rv); chk_reg(rv, 8'h00);
        // byte halves of a timing register, high byte only five bits wide
        wr(`ACS_OFF_PRE_H, 8'hFF); wr(`ACS_OFF_PRE_L, 8'hA5);
        rd(`ACS_OFF_PRE_H, rv); chk_reg(rv, 8'h1F);
        rd(`ACS_OFF_PRE_L, rv); chk_reg(rv, 8'hA5);
        wr(10'h3F0, 8'h55);
        rd(10'h3F0, rv); chk_reg(rv, 8'h00);
        // every reference code, reserved positive code routes nothing
        for (int r = 0; r < 8; r++) begin
            wr(`ACS_OFF_REF, {3'h0, r[2], 2'h0, r[1:0]});
            repeat (2) @(posedge mclk);
            er = '{r[2], r[1:0] == 2'h3, r[1:0] == 2'h2, r[1:0] == 2'h0};
            #1 chk_pin(ref_sel, er);
        end
        // every channel code, unassigned codes connect nothing
        for (int c = 0; c < 64; c++) begin
            wr(`ACS_OFF_PCH, c[7:0]);
            repeat (2) @(posedge mclk);
            #1 chk_pin(chan_sel, chan_exp(c));
        end
        // divider period on the system clock
        for (int n = 0; n < 6; n += 3) begin
            wr(`ACS_OFF_CLK, n[7:0]);
            wait_tick(gap);
            wait_tick(gap);
            chk_pin(gap, 2 * (n + 1));
        end
        // rc source: one tick per rc rising edge, divider of two ignored
        wr(`ACS_OFF_CLK, 8'h02);
        wr(`ACS_OFF_CTRL, 8'h02);
        cnt = 0;
        for (int k = 0; k < 48; k++) begin
            @(posedge mclk);
            rc_clk_pin <= (k < 40) && (k % 10 >= 5);
            #1 if (adc_clk_tick === 1'b1) cnt++;
        end
        chk_pin(cnt, 4);
        wr(`ACS_OFF_CTRL, 8'h00);
        // single samples: normal, no precharge, both zero, long acquisition
        wr(`ACS_OFF_PRE_H, 8'h00); wr(`ACS_OFF_PRE_L, 8'h02); wr(`ACS_OFF_ACQ_L, 8'h01);
        wr(`ACS_OFF_CTRL, 8'h01); run_sample(2, 1, 1'b0);
        wr(`ACS_OFF_PRE_L, 8'h00); wr(`ACS_OFF_ACQ_L, 8'h03);
        wr(`ACS_OFF_CTRL, 8'h01); run_sample(0, 3, 1'b0);
        wr(`ACS_OFF_ACQ_L, 8'h00);
        wr(`ACS_OFF_CTRL, 8'h01); run_sample(0, 0, 1'b0);
        wr(`ACS_OFF_PRE_L, 8'h01);
        wr(`ACS_OFF_CTRL, 8'h01); run_sample(1, 8192, 1'b0);
        repeat (3) @(posedge mclk);
        rd(`ACS_OFF_STAT, rv); chk_reg(rv, 8'h00);
        rd(`ACS_OFF_IRQ_STAT, rv);
        // double sample without continuous: suspension, flag held, interrupts
        wr(`ACS_OFF_PRE_L, 8'h02); wr(`ACS_OFF_ACQ_L, 8'h01);
        wr(`ACS_OFF_IRQ_MASK, 8'h03);
        wr(`ACS_OFF_CTRL, 8'h05); run_sample(2, 1, 1'b0);
        pulse(2);
        repeat (3) @(posedge mclk);
        rd(`ACS_OFF_STAT, rv); chk_reg(rv, 8'h14);
        wr(`ACS_OFF_STAT, 8'h00);
        rd(`ACS_OFF_STAT, rv); chk_reg(rv, 8'h14);
        chk_pin(irq, 1'b1);
        rd(`ACS_OFF_IRQ_STAT, rv); chk_reg(rv, 8'h03);
        @(posedge mclk);
        #1 chk_pin(irq, 1'b0);
        pulse(0); run_sample(2, 1, 1'b1);
        repeat (3) @(posedge mclk);
        rd(`ACS_OFF_STAT, rv); chk_reg(rv, 8'h10);
        wr(`ACS_OFF_STAT, 8'h00);
        rd(`ACS_OFF_STAT, rv); chk_reg(rv, 8'h00);
        // mask hides a pending sample event, unmasking shows it again
        wr(`ACS_OFF_IRQ_MASK, 8'h00);
        #1 chk_pin(irq, 1'b0);
        wr(`ACS_OFF_IRQ_MASK, 8'h01);
        #1 chk_pin(irq, 1'b1);
        rd(`ACS_OFF_IRQ_STAT, rv); chk_reg(rv, 8'h01);
        @(posedge mclk);
        #1 chk_pin(irq, 1'b0);
        give_verdict();
    end
endmodule : tb_acs_top
